// >>> aecs_host_model.sv
// Host-side partner: sample clock source and output clock reset driver
`timescale 1ns/100ps
`default_nettype none

module aecs_host_model (
   // Requests from the bench
   input  wire logic hold_req_i,
   input  wire logic cal_i,
   // Watched output clock
   input  wire logic output_data_clock_i,
   // Pins toward the block, and the rise count for the bench
   output logic      sample_clk_o,
   output logic      ocr_o,
   output var int    rise_cnt_o
);
   logic seen;

   initial begin
      sample_clk_o = 1'b0;
      ocr_o = 1'b0;
      rise_cnt_o = 0;
      seen = 1'b1;
      forever #62.5 sample_clk_o = ~sample_clk_o;
   end

   always @(posedge sample_clk_o) begin
      if (hold_req_i && !cal_i) ocr_o <= 1'b1;
      else if (!hold_req_i) ocr_o <= 1'b0;
   end

   // Sample rises from release to first clock edge
   always @(posedge sample_clk_o) begin
      if (ocr_o) rise_cnt_o <= 0;
      else if (!seen) rise_cnt_o <= rise_cnt_o + 1;
   end

   always @(posedge ocr_o) seen = 1'b0;
   always @(output_data_clock_i) if (!ocr_o) seen = 1'b1;
endmodule // aecs_host_model

`default_nettype wire

// >>> aecs_pkg.sv
// Package for the extended converter control and output clock sync block
package aecs_pkg;

   // Register indices on the programming port
   localparam logic [3:0] OFF_EXT_CFG     = 4'h9;
   localparam logic [3:0] OFF_Q_OFFSET    = 4'ha;
   localparam logic [3:0] OFF_Q_GAIN      = 4'hb;
   localparam logic [3:0] OFF_PHASE_FINE  = 4'he;
   localparam logic [3:0] OFF_PHASE_COARS = 4'hf;

   // Reset values
   localparam logic [15:0] RST_EXT_CFG     = 16'h03ff;
   localparam logic [15:0] RST_Q_OFFSET    = 16'h007f;
   localparam logic [15:0] RST_Q_GAIN      = 16'h807f;
   localparam logic [15:0] RST_PHASE_FINE  = 16'h00ff;
   localparam logic [15:0] RST_PHASE_COARS = 16'h007f;

   // Field positions
   localparam int BIT_PATTERN   = 15;
   localparam int BIT_TRIM_DIS  = 14;
   localparam int BIT_DUAL_EDGE = 13;
   localparam int BIT_IN_SEL    = 12;
   localparam int BIT_LOW_CLK   = 10;
   localparam int BIT_OFS_SIGN  = 7;
   localparam int BIT_INVERT    = 15;
   localparam int POS_OFS_MAG   = 8;
   localparam int POS_GAIN      = 7;
   localparam int POS_FINE      = 8;
   localparam int POS_COARSE    = 10;
   localparam int POS_INTER     = 7;

   // Output clock restart delay in sample clock cycles
   localparam logic [2:0] DELAY_DEMUX_DDR0 = 3'h4;
   localparam logic [2:0] DELAY_OTHER      = 3'h3;

   // Pattern base words per port
   localparam logic [7:0] PAT_QD = 8'h01;
   localparam logic [7:0] PAT_ID = 8'h02;
   localparam logic [7:0] PAT_Q  = 8'h03;
   localparam logic [7:0] PAT_I  = 8'h04;

   typedef struct packed {
      logic       pattern_output_select;
      logic       termination_trim_disable;
      logic       dual_edge_sampling;
      logic       interleave_input_select;
      logic       low_clock_tuning;
      logic [7:0] q_offset_mag;
      logic       q_offset_negative;
      logic [8:0] q_gain;
      logic [7:0] fine_phase;
      logic       sample_clock_invert;
      logic [4:0] coarse_phase;
      logic [2:0] intermediate_phase;
   } aecs_cfg_t;

   typedef struct packed {
      logic [7:0] i;
      logic [7:0] q;
      logic [7:0] id;
      logic [7:0] qd;
      logic       range;
   } aecs_dat_t;

   typedef enum logic [1:0] {ST_RUN, ST_HELD, ST_WAIT_FALL, ST_DELAY} aecs_state_t;

endpackage

// >>> aecs_top.sv
// Extended control registers and output data clock reset/synchronization
`timescale 1ns/100ps
`default_nettype none

module aecs_top (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // Register write port
   input  wire logic              wr_en_i,
   input  wire logic [3:0]        wr_addr_i,
   input  wire logic [15:0]       wr_data_i,
   // Device pins
   input  wire logic              sample_clk_i,
   input  wire logic              output_clock_reset_i,
   input  wire logic              ext_mode_i,
   // Mode and status from device logic
   input  wire logic              sdr_mode_i,
   input  wire logic              output_edge_select_i,
   input  wire logic              ddr_clock_phase_i,
   input  wire logic              calibration_running_i,
   input  wire aecs_pkg::aecs_dat_t conv_data_i,
   // Applied settings
   output var aecs_pkg::aecs_cfg_t cfg_o,
   output logic                   trim_skip_o,
   // Output data and clock
   output var aecs_pkg::aecs_dat_t data_o,
   output logic                   output_data_clock_o
);

   // Field extraction shared by live registers and reset defaults
   function automatic aecs_pkg::aecs_cfg_t decode(input logic [15:0] ext, input logic [15:0] ofs,
                                                 input logic [15:0] gain, input logic [15:0] fine,
                                                 input logic [15:0] crs);
      aecs_pkg::aecs_cfg_t c;
      c.pattern_output_select    = ext[aecs_pkg::BIT_PATTERN];
      c.termination_trim_disable = ext[aecs_pkg::BIT_TRIM_DIS];
      c.dual_edge_sampling       = ext[aecs_pkg::BIT_DUAL_EDGE];
      c.interleave_input_select  = ext[aecs_pkg::BIT_IN_SEL];
      c.low_clock_tuning         = ext[aecs_pkg::BIT_LOW_CLK];
      c.q_offset_mag             = ofs[aecs_pkg::POS_OFS_MAG +: 8];
      c.q_offset_negative        = ofs[aecs_pkg::BIT_OFS_SIGN];
      c.q_gain                   = gain[aecs_pkg::POS_GAIN +: 9];
      c.fine_phase               = fine[aecs_pkg::POS_FINE +: 8];
      c.sample_clock_invert      = crs[aecs_pkg::BIT_INVERT];
      c.coarse_phase             = crs[aecs_pkg::POS_COARSE +: 5];
      c.intermediate_phase       = crs[aecs_pkg::POS_INTER +: 3];
      return c;
   endfunction

   localparam aecs_pkg::aecs_cfg_t CFG_DEFAULT = decode(aecs_pkg::RST_EXT_CFG,
      aecs_pkg::RST_Q_OFFSET, aecs_pkg::RST_Q_GAIN, aecs_pkg::RST_PHASE_FINE,
      aecs_pkg::RST_PHASE_COARS);

   // Pin synchronizers
   logic [1:0] sclk_sync_reg, sclk_sync_next;
   logic [1:0] rst_sync_reg,  rst_sync_next;
   logic [1:0] ext_sync_reg,  ext_sync_next;
   logic       sclk_prev_reg, sclk_prev_next;
   logic       s_rise, s_fall, rst_s, ext_s;

   always_comb begin
      sclk_sync_next = {sclk_sync_reg[0], sample_clk_i};
      rst_sync_next  = {rst_sync_reg[0], output_clock_reset_i};
      ext_sync_next  = {ext_sync_reg[0], ext_mode_i};
      sclk_prev_next = sclk_sync_reg[1];
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sclk_sync_reg <= 2'h0;
         rst_sync_reg  <= 2'h0;
         ext_sync_reg  <= 2'h0;
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_sync_reg <= sclk_sync_next;
         rst_sync_reg  <= rst_sync_next;
         ext_sync_reg  <= ext_sync_next;
         sclk_prev_reg <= sclk_prev_next;
      end
   end

   assign s_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
   assign s_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
   assign rst_s  = rst_sync_reg[1];
   assign ext_s  = ext_sync_reg[1];

   // Write-only register file, no read port at all
   logic [15:0] ext_cfg_reg, ext_cfg_next;
   logic [15:0] q_ofs_reg,   q_ofs_next;
   logic [15:0] q_gain_reg,  q_gain_next;
   logic [15:0] fine_reg,    fine_next;
   logic [15:0] coarse_reg,  coarse_next;
   aecs_pkg::aecs_cfg_t cfg_next;

   always_comb begin
      ext_cfg_next = ext_cfg_reg;
      q_ofs_next   = q_ofs_reg;
      q_gain_next  = q_gain_reg;
      fine_next    = fine_reg;
      coarse_next  = coarse_reg;
      if (wr_en_i && wr_addr_i == aecs_pkg::OFF_EXT_CFG) begin
         ext_cfg_next = wr_data_i;
      end else if (wr_en_i && wr_addr_i == aecs_pkg::OFF_Q_OFFSET) begin
         q_ofs_next = wr_data_i;
      end else if (wr_en_i && wr_addr_i == aecs_pkg::OFF_Q_GAIN) begin
         q_gain_next = wr_data_i;
      end else if (wr_en_i && wr_addr_i == aecs_pkg::OFF_PHASE_FINE) begin
         fine_next = wr_data_i;
      end else if (wr_en_i && wr_addr_i == aecs_pkg::OFF_PHASE_COARS) begin
         coarse_next = wr_data_i;
      end
      cfg_next = ext_s ? decode(ext_cfg_reg, q_ofs_reg, q_gain_reg, fine_reg, coarse_reg)
                       : CFG_DEFAULT;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ext_cfg_reg <= aecs_pkg::RST_EXT_CFG;
         q_ofs_reg   <= aecs_pkg::RST_Q_OFFSET;
         q_gain_reg  <= aecs_pkg::RST_Q_GAIN;
         fine_reg    <= aecs_pkg::RST_PHASE_FINE;
         coarse_reg  <= aecs_pkg::RST_PHASE_COARS;
         cfg_o       <= CFG_DEFAULT;
      end else begin
         ext_cfg_reg <= ext_cfg_next;
         q_ofs_reg   <= q_ofs_next;
         q_gain_reg  <= q_gain_next;
         fine_reg    <= fine_next;
         coarse_reg  <= coarse_next;
         cfg_o       <= cfg_next;
      end
   end

   // Output clock reset, sync and pattern
   aecs_pkg::aecs_state_t state_reg, state_next;
   logic [2:0]  cnt_reg, cnt_next;
   logic        pat_phase_reg, pat_phase_next;
   logic        output_data_clock_next, trim_next;
   logic        hold_level, cal_stop;
   logic [2:0]  delay_target;
   aecs_pkg::aecs_dat_t data_next, pat_word;

   always_comb begin
      hold_level   = sdr_mode_i ? output_edge_select_i : 1'b0;
      delay_target = (!sdr_mode_i && !output_edge_select_i && !ddr_clock_phase_i) ?
                     aecs_pkg::DELAY_DEMUX_DDR0 : aecs_pkg::DELAY_OTHER;
      // stop clock during calibration unless trim disabled
      cal_stop     = calibration_running_i && !cfg_o.termination_trim_disable;
      trim_next    = calibration_running_i && cfg_o.termination_trim_disable;
      pat_word.qd  = pat_phase_reg ? ~aecs_pkg::PAT_QD : aecs_pkg::PAT_QD;
      pat_word.id  = pat_phase_reg ? ~aecs_pkg::PAT_ID : aecs_pkg::PAT_ID;
      pat_word.q   = pat_phase_reg ? ~aecs_pkg::PAT_Q : aecs_pkg::PAT_Q;
      pat_word.i   = pat_phase_reg ? ~aecs_pkg::PAT_I : aecs_pkg::PAT_I;
      pat_word.range = pat_phase_reg;
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      pat_phase_next = pat_phase_reg;
      output_data_clock_next      = output_data_clock_o;
      data_next      = data_o;
      case (state_reg)
         aecs_pkg::ST_RUN: begin
            if (s_rise && !cal_stop) begin
               output_data_clock_next      = ~output_data_clock_o;
               pat_phase_next = ~pat_phase_reg;
               // pattern replaces data in every output mode
               data_next      = cfg_o.pattern_output_select ? pat_word : conv_data_i;
            end
         end
         aecs_pkg::ST_HELD: begin
            output_data_clock_next      = hold_level;
            // pattern restarts from its first word
            pat_phase_next = 1'b0;
            if (!rst_s) begin
               state_next = aecs_pkg::ST_WAIT_FALL;
            end
         end
         aecs_pkg::ST_WAIT_FALL: begin
            output_data_clock_next = hold_level;
            // release taken on sample falling edge
            if (s_fall) begin
               state_next = aecs_pkg::ST_DELAY;
               cnt_next   = 3'h0;
            end
         end
         aecs_pkg::ST_DELAY: begin
            output_data_clock_next = hold_level;
            // clock reappears on last counted rise
            if (s_rise) begin
               cnt_next = cnt_reg + 3'h1;
               if (cnt_reg == delay_target - 3'h1) begin
                  state_next     = aecs_pkg::ST_RUN;
                  // First edge after restart carries the first word
                  output_data_clock_next      = ~hold_level;
                  pat_phase_next = ~pat_phase_reg;
                  data_next      = cfg_o.pattern_output_select ? pat_word : conv_data_i;
               end
            end
         end
         default: state_next = aecs_pkg::ST_HELD;
      endcase
      if (rst_s) begin
         state_next = aecs_pkg::ST_HELD;
         output_data_clock_next  = hold_level;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_reg           <= aecs_pkg::ST_RUN;
         cnt_reg             <= 3'h0;
         pat_phase_reg       <= 1'b0;
         output_data_clock_o <= 1'b0;
         data_o              <= '0;
         trim_skip_o         <= 1'b0;
      end else begin
         state_reg           <= state_next;
         cnt_reg             <= cnt_next;
         pat_phase_reg       <= pat_phase_next;
         output_data_clock_o <= output_data_clock_next;
         data_o              <= data_next;
         trim_skip_o         <= trim_next;
      end
   end

   // Checks
   AST_WRITE_APPLY: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_en_i && wr_addr_i == aecs_pkg::OFF_Q_GAIN && ext_s ##1 ext_s |=>
      cfg_o.q_gain == $past(wr_data_i[15:7], 2))
      else $error("Gain write not applied");
   AST_NORMAL_IGNORES: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !ext_s |=> cfg_o == CFG_DEFAULT)
      else $error("Registers applied in normal mode");
   AST_PATTERN_OUT: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == aecs_pkg::ST_RUN && s_rise && !cal_stop && cfg_o.pattern_output_select &&
      !rst_s
      |=> data_o == $past(pat_word))
      else $error("Pattern not on outputs");
   AST_CAL_STOP: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == aecs_pkg::ST_RUN && cal_stop && !rst_s |=> $stable(output_data_clock_o))
      else $error("Output clock ran during calibration");
   AST_GAIN_RESET: assert property (@(posedge clk_i)
      $rose(nrst_i) |-> cfg_o.q_gain == 9'h100)
      else $error("Gain reset value wrong");
   AST_HELD_LEVEL: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rst_s ##1 rst_s |-> ##1 output_data_clock_o == $past(hold_level))
      else $error("Output clock not held");
   AST_FALL_LATCH: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == aecs_pkg::ST_WAIT_FALL && !s_fall && !rst_s |=>
      state_reg == aecs_pkg::ST_WAIT_FALL)
      else $error("Release taken before falling edge");
   AST_RESTART_COUNT: assert property (@(posedge clk_i) disable iff (!nrst_i)
      $past(state_reg) == aecs_pkg::ST_DELAY && state_reg == aecs_pkg::ST_RUN |->
      $past(cnt_reg) == $past(delay_target) - 3'h1 && $past(s_rise) &&
      output_data_clock_o != $past(output_data_clock_o))
      else $error("Output clock restart count wrong");
   AST_PATTERN_ALIGN: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == aecs_pkg::ST_DELAY |-> !pat_phase_reg)
      else $error("Pattern not aligned at release");

   COV_RESTART: cover property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == aecs_pkg::ST_DELAY ##1 state_reg == aecs_pkg::ST_RUN);
   COV_PATTERN: cover property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == aecs_pkg::ST_RUN && cfg_o.pattern_output_select && s_rise);
   COV_CAL_TRIM: cover property (@(posedge clk_i) disable iff (!nrst_i)
      trim_skip_o && output_data_clock_o != $past(output_data_clock_o));

endmodule // aecs_top

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the extended control and output clock sync block
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic                clk_i;
   logic                nrst_i;
   logic                wr_en_i;
   logic [3:0]          wr_addr_i;
   logic [15:0]         wr_data_i;
   logic                ext_mode_i;
   logic                sdr_mode_i;
   logic                output_edge_select_i;
   logic                ddr_clock_phase_i;
   logic                calibration_running_i;
   logic                hold_req;
   logic                sample_clk;
   logic                ocr;
   logic                trim_skip_o;
   logic                output_data_clock;
   int                  rise_cnt;
   int                  n_fail;
   int                  check_count;
   aecs_pkg::aecs_dat_t conv_data_i;
   aecs_pkg::aecs_dat_t data_o;
   aecs_pkg::aecs_dat_t pat0;
   aecs_pkg::aecs_cfg_t cfg_o;
   aecs_pkg::aecs_cfg_t dflt;
   aecs_pkg::aecs_cfg_t prog;

   aecs_top aecs_top_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
      .wr_data_i(wr_data_i), .sample_clk_i(sample_clk), .output_clock_reset_i(ocr),
      .ext_mode_i(ext_mode_i), .sdr_mode_i(sdr_mode_i),
      .output_edge_select_i(output_edge_select_i), .ddr_clock_phase_i(ddr_clock_phase_i),
      .calibration_running_i(calibration_running_i), .conv_data_i(conv_data_i),
      .cfg_o(cfg_o), .trim_skip_o(trim_skip_o), .data_o(data_o),
      .output_data_clock_o(output_data_clock));

   aecs_host_model aecs_host_model_inst (
      .hold_req_i(hold_req), .cal_i(calibration_running_i), .output_data_clock_i(output_data_clock),
      .sample_clk_o(sample_clk), .ocr_o(ocr), .rise_cnt_o(rise_cnt));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk_cfg(input aecs_pkg::aecs_cfg_t got, input aecs_pkg::aecs_cfg_t exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_dat(input aecs_pkg::aecs_dat_t got, input aecs_pkg::aecs_dat_t exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      wr_en_i <= 1'b1;
      wr_addr_i <= a;
      wr_data_i <= d;
      @(posedge clk_i);
   endtask

   // Ends on a falling edge right after the output clock moved
   task automatic wait_output_data_clock(output logic ok);
      logic old;
      old = output_data_clock;
      ok = 1'b0;
      repeat (300) begin
         @(negedge clk_i);
         if (output_data_clock !== old) begin
            ok = 1'b1;
            break;
         end
      end
   endtask

   task automatic t_write();
      wr(4'h9, 16'hf7ff);
      wr(4'ha, 16'ha5ff);
      wr(4'hb, 16'he07f);
      wr(4'he, 16'h5aff);
      wr(4'hf, 16'hd6ff);
      wr(4'h8, 16'h0000);
      wr(4'hc, 16'h0000);
      wr_en_i <= 1'b0;
      cyc(3);
      @(negedge clk_i);
      chk_cfg(cfg_o, prog);
      @(posedge clk_i);
   endtask

   task automatic t_normal();
      ext_mode_i <= 1'b0;
      cyc(6);
      @(negedge clk_i);
      chk_cfg(cfg_o, dflt);
      @(posedge clk_i);
      ext_mode_i <= 1'b1;
      cyc(6);
      @(negedge clk_i);
      chk_cfg(cfg_o, prog);
      @(posedge clk_i);
   endtask

   task automatic t_sync(input logic sdr, input logic oes, input logic ph, input int n);
      logic ok;
      sdr_mode_i <= sdr;
      ddr_clock_phase_i <= ph;
      output_edge_select_i <= oes;
      hold_req <= 1'b1;
      cyc(40);
      wr(4'h9, 16'hf7ff);
      wr_en_i <= 1'b0;
      cyc(20);
      @(negedge clk_i);
      chk_val(output_data_clock, sdr & oes);
      cyc(20);
      @(negedge clk_i);
      chk_val(output_data_clock, sdr & oes);
      @(posedge clk_i);
      hold_req <= 1'b0;
      wait_output_data_clock(ok);
      chk_val(ok, 1);
      chk_val(rise_cnt, n);
      chk_dat(data_o, pat0);
      wait_output_data_clock(ok);
      chk_dat(data_o, ~pat0);
      @(posedge clk_i);
   endtask

   task automatic t_cal();
      logic ok;
      logic old;
      wr(4'h9, 16'h03ff);
      wr_en_i <= 1'b0;
      cyc(4);
      calibration_running_i <= 1'b1;
      cyc(4);
      @(negedge clk_i);
      old = output_data_clock;
      chk_val(trim_skip_o, 0);
      cyc(60);
      @(negedge clk_i);
      chk_val(output_data_clock, old);
      @(posedge clk_i);
      wr(4'h9, 16'h43ff);
      wr_en_i <= 1'b0;
      cyc(4);
      wait_output_data_clock(ok);
      chk_val(ok, 1);
      chk_val(trim_skip_o, 1);
      chk_dat(data_o, conv_data_i);
      @(posedge clk_i);
      calibration_running_i <= 1'b0;
   endtask

   initial begin
      nrst_i = 1'b0;
      wr_en_i = 1'b0;
      wr_addr_i = 4'h0;
      wr_data_i = 16'h0000;
      ext_mode_i = 1'b1;
      sdr_mode_i = 1'b0;
      output_edge_select_i = 1'b0;
      ddr_clock_phase_i = 1'b0;
      calibration_running_i = 1'b0;
      hold_req = 1'b0;
      n_fail = 0;
      check_count = 0;
      conv_data_i = {8'h11, 8'h22, 8'h33, 8'h44, 1'b1};
      pat0 = {8'h04, 8'h03, 8'h02, 8'h01, 1'b0};
      dflt = '0;
      dflt.q_gain = 9'h100;
      prog = {5'h1f, 8'ha5, 1'b1, 9'h1c0, 8'h5a, 1'b1, 5'h15, 3'h5};
      cyc(16);
      nrst_i <= 1'b1;
      cyc(4);
      @(negedge clk_i);
      chk_cfg(cfg_o, dflt);
      @(posedge clk_i);
      t_write();
      t_normal();
      t_sync(1'b0, 1'b0, 1'b0, 4);
      t_sync(1'b1, 1'b1, 1'b0, 3);
      t_sync(1'b0, 1'b1, 1'b0, 3);
      t_sync(1'b0, 1'b0, 1'b1, 3);
      t_cal();
      tally_and_finish();
   end

   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end
endmodule // tb

`default_nettype wire
